// File: src/bspi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bspi_defines.svh"

// Operation
// - Echo first byte at measured rate
// - Echo correct second byte, else silence
// - Command 0xC0 accepted and echoed
// - Bad command answered with error code
// - Error code sent thrice, then idle
// - Start mark 0x3A then count 0x13
// - First payload byte 0x03, address length
// - ROM size 0x80, block count 0x01
// - Flash range 0x008000 to 0x00FFFF
// - Loader range 0x000060 to 0x00083F
// - Addresses sent high byte first
// - Last byte is negated payload sum
// - Then wait for next command
module bspi_top (
   // Clock, reset, enable
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic ce,
   // Serial link pins
   input  wire logic rxd,
   output logic      txd,
   // Status
   output logic      baud_locked,
   output logic      cmd_wait,
   output logic      halted
);

   localparam int CW = `BSPI_CNT_W;

   bspi_pkg::bspi_state_t state;
   bspi_pkg::bspi_phase_t rx_ph;
   bspi_pkg::bspi_phase_t tx_ph;

   logic          rx_meta;
   logic          rx_sync;
   logic          rx_prev;
   logic          rx_fall;
   logic          rx_rise;
   logic [CW-1:0] ab_cnt;
   logic [CW-1:0] low_len;
   logic [CW-1:0] bit_len;
   logic [CW-1:0] bit_end;
   logic [19:0]   l20;
   logic [19:0]   h20;
   logic          is86;
   logic          is30;
   logic          ab_good;
   logic [7:0]    ab_byte;
   logic          ab_ok;
   logic          stop_hit;
   logic [7:0]    echo_byte;
   bspi_pkg::bspi_state_t echo_next;
   logic [7:0]    err_code;
   logic [1:0]    err_cnt;
   logic          ovr;
   logic [4:0]    idx;
   logic [7:0]    sum;
   logic [7:0]    reply_byte;
   logic          rx_on;
   logic [CW-1:0] rx_cnt;
   logic [2:0]    rx_bit;
   logic [7:0]    rx_shift;
   logic          rx_valid;
   logic          rx_ferr;
   logic [CW-1:0] tx_cnt;
   logic [2:0]    tx_bit;
   logic [7:0]    tx_shift;
   logic          f_in_valid;
   logic          f_in_ready;
   logic [7:0]    f_in_data;
   logic          f_out_valid;
   logic          f_out_ready;
   logic [7:0]    f_out_data;
   logic          push;

   // Autobaud phases, used by several decodes
   function automatic logic in_ab(bspi_pkg::bspi_state_t s);
      return s == bspi_pkg::ST_AB_WAIT || s == bspi_pkg::ST_AB_LOW ||
             s == bspi_pkg::ST_AB_HIGH || s == bspi_pkg::ST_AB_TAIL;
   endfunction

   // Fixed report content by position
   function automatic logic [7:0] info_byte(logic [4:0] i);
      logic [7:0] b;
      b = `BSPI_RSV_ZERO;
      unique case (i)
         5'h00: b = `BSPI_CMD_INFO;
         5'h01: b = `BSPI_START_MARK;
         5'h02: b = `BSPI_PAYLOAD_CNT;
         5'h03: b = `BSPI_ADDR_LEN;
         5'h04: b = `BSPI_RSV_FIRST;
         5'h05: b = `BSPI_RSV_ZERO;
         5'h06: b = `BSPI_RSV_ZERO;
         5'h07: b = `BSPI_RSV_ZERO;
         5'h08: b = `BSPI_ROM_SIZE;
         5'h09: b = `BSPI_ROM_BLOCKS;
         5'h0A: b = 8'(`BSPI_FLASH_START >> 16);
         5'h0B: b = 8'(`BSPI_FLASH_START >> 8);
         5'h0C: b = 8'(`BSPI_FLASH_START);
         5'h0D: b = 8'(`BSPI_FLASH_END >> 16);
         5'h0E: b = 8'(`BSPI_FLASH_END >> 8);
         5'h0F: b = 8'(`BSPI_FLASH_END);
         5'h10: b = 8'(`BSPI_RAM_START >> 16);
         5'h11: b = 8'(`BSPI_RAM_START >> 8);
         5'h12: b = 8'(`BSPI_RAM_START);
         5'h13: b = 8'(`BSPI_RAM_END >> 16);
         5'h14: b = 8'(`BSPI_RAM_END >> 8);
         5'h15: b = 8'(`BSPI_RAM_END);
         default: b = `BSPI_RSV_ZERO;
      endcase
      return b;
   endfunction

   // Pin synchroniser; edges only look at the second stage onward
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else if (ce) begin
         rx_meta <= rxd;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   assign rx_fall = rx_prev && !rx_sync;
   assign rx_rise = !rx_prev && rx_sync;
   assign bit_end = bit_len - CW'(1);

   // A sync byte starts with two low bits then two high bits
   // after the start edge only for 0x86; 0x30 has five low, two high.
   // The high run is two bits in both, so it sets the bit time.
   assign h20     = {4'h0, ab_cnt};
   assign l20     = {2'h0, low_len, 2'h0};
   assign is86    = l20 >= h20 * 20'h00003 && l20 <= h20 * 20'h00005;
   assign is30    = l20 >= h20 * 20'h00009 && l20 <= h20 * 20'h0000B;
   assign ab_good = (is86 || is30) && {1'b0, ab_cnt[CW-1:1]} >= `BSPI_MIN_BIT;

   // Autobaud run-length measurement
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ab_cnt  <= `BSPI_CNT_RST;
         low_len <= `BSPI_CNT_RST;
         bit_len <= `BSPI_MIN_BIT;
      end else if (ce) begin
         if (state == bspi_pkg::ST_AB_WAIT) begin
            ab_cnt <= CW'(1);
         end else if (state == bspi_pkg::ST_AB_LOW && rx_rise) begin
            low_len <= ab_cnt;
            ab_cnt  <= CW'(1);
         end else if (state == bspi_pkg::ST_AB_HIGH && rx_fall) begin
            bit_len <= {1'b0, ab_cnt[CW-1:1]};
            ab_cnt  <= CW'(1);
         end else if (state == bspi_pkg::ST_AB_TAIL && !rx_sync) begin
            ab_cnt <= CW'(1);
         end else if (in_ab(state)) begin
            ab_cnt <= ab_cnt + {15'h0000, ~&ab_cnt};        // Saturates
         end
      end
   end

   // Line idle for two bit times marks the end of the first byte
   assign stop_hit = rx_sync && ab_cnt >= {bit_len[CW-2:0], 1'b0};

   // Command sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state     <= bspi_pkg::ST_AB_WAIT;
         ab_byte   <= `BSPI_SYNC1_A;
         ab_ok     <= 1'b0;
         echo_byte <= `BSPI_SYNC1_A;
         echo_next <= bspi_pkg::ST_SYNC2;
         err_code  <= `BSPI_ERR_CMD;
         err_cnt   <= 2'h0;
         ovr       <= 1'b0;
      end else if (ce) begin
         unique case (state)
            bspi_pkg::ST_AB_WAIT: begin
               if (rx_fall) begin
                  state <= bspi_pkg::ST_AB_LOW;
               end
            end
            bspi_pkg::ST_AB_LOW: begin
               if (rx_rise) begin
                  state <= bspi_pkg::ST_AB_HIGH;
               end else if (&ab_cnt) begin
                  state <= bspi_pkg::ST_AB_WAIT;
               end
            end
            bspi_pkg::ST_AB_HIGH: begin
               if (rx_fall) begin
                  ab_ok   <= ab_good;
                  ab_byte <= is86 ? `BSPI_SYNC1_A : `BSPI_SYNC1_B;
                  state   <= bspi_pkg::ST_AB_TAIL;
               end else if (&ab_cnt) begin
                  state <= bspi_pkg::ST_AB_WAIT;
               end
            end
            bspi_pkg::ST_AB_TAIL: begin
               if (stop_hit) begin
                  if (ab_ok) begin
                     echo_byte <= ab_byte;
                     echo_next <= bspi_pkg::ST_SYNC2;
                     state     <= bspi_pkg::ST_ECHO;
                  end else begin
                     state <= bspi_pkg::ST_AB_WAIT;
                  end
               end
            end
            bspi_pkg::ST_ECHO: begin
               if (push) begin
                  state <= echo_next;
               end
            end
            bspi_pkg::ST_SYNC2: begin
               if (rx_valid) begin
                  if (!rx_ferr && (rx_shift == `BSPI_SYNC2_A ||
                                   rx_shift == `BSPI_SYNC2_B)) begin
                     echo_byte <= rx_shift;
                     echo_next <= bspi_pkg::ST_CMD;
                     state     <= bspi_pkg::ST_ECHO;
                  end else begin
                     state <= bspi_pkg::ST_AB_WAIT;
                  end
               end
            end
            bspi_pkg::ST_CMD: begin
               ovr <= 1'b0;
               if (rx_valid) begin
                  if (rx_ferr) begin
                     err_code <= `BSPI_ERR_FRAME;
                     state    <= bspi_pkg::ST_ERR;
                  end else if (rx_shift == `BSPI_CMD_INFO) begin
                     state <= bspi_pkg::ST_REPLY;
                  end else begin
                     err_code <= `BSPI_ERR_CMD;
                     state    <= bspi_pkg::ST_ERR;
                  end
               end
            end
            bspi_pkg::ST_REPLY: begin
               // A byte arriving mid-report must not be dropped silently
               if (rx_valid) begin
                  ovr <= 1'b1;
               end
               if (push && idx == `BSPI_IDX_LAST) begin
                  if (ovr || rx_valid) begin
                     err_code <= `BSPI_ERR_OVR;
                     state    <= bspi_pkg::ST_ERR;
                  end else begin
                     state <= bspi_pkg::ST_CMD;
                  end
               end
            end
            bspi_pkg::ST_ERR: begin
               // Pushes stop at three, so the count never wraps
               if (push) begin
                  err_cnt <= err_cnt + 2'h1;
               end
            end
            default: begin
               state <= bspi_pkg::ST_AB_WAIT;
            end
         endcase
      end
   end

   // Report position and running payload sum
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         idx <= 5'h00;
         sum <= 8'h00;
      end else if (ce) begin
         if (state != bspi_pkg::ST_REPLY) begin
            idx <= 5'h00;
            sum <= 8'h00;
         end else if (push) begin
            idx <= idx + 5'h01;
            if (idx >= `BSPI_IDX_PAY_LO && idx <= `BSPI_IDX_PAY_HI) begin
               sum <= sum + reply_byte;
            end
         end
      end
   end

   // Checksum wraps in eight bits, so payload plus it is zero
   assign reply_byte = (idx == `BSPI_IDX_LAST) ? 8'h00 - sum : info_byte(idx);

   // Feed the transmit queue; the error burst stops after three codes
   assign f_in_valid = state == bspi_pkg::ST_ECHO || state == bspi_pkg::ST_REPLY ||
                       (state == bspi_pkg::ST_ERR && err_cnt != `BSPI_ERR_LAST);
   assign f_in_data  = state == bspi_pkg::ST_ECHO  ? echo_byte :
                       state == bspi_pkg::ST_REPLY ? reply_byte : err_code;
   assign push       = f_in_valid && f_in_ready;

   // Receiver only listens once the rate is known and before any error
   assign rx_on = !in_ab(state) && state != bspi_pkg::ST_ERR;

   // Byte receiver at the measured bit time, LSB first
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_ph    <= bspi_pkg::PH_IDLE;
         rx_cnt   <= `BSPI_CNT_RST;
         rx_bit   <= 3'h0;
         rx_shift <= 8'h00;
         rx_valid <= 1'b0;
         rx_ferr  <= 1'b0;
      end else if (ce) begin
         rx_valid <= 1'b0;
         rx_cnt   <= rx_cnt + CW'(1);
         if (!rx_on) begin
            rx_ph <= bspi_pkg::PH_IDLE;
         end else begin
            unique case (rx_ph)
               bspi_pkg::PH_IDLE: begin
                  rx_cnt <= `BSPI_CNT_RST;
                  if (rx_fall) begin
                     rx_ph <= bspi_pkg::PH_START;
                  end
               end
               bspi_pkg::PH_START: begin
                  // Mid start bit rejects short glitches
                  if (rx_cnt == {1'b0, bit_len[CW-1:1]}) begin
                     rx_cnt <= `BSPI_CNT_RST;
                     rx_bit <= 3'h0;
                     rx_ph  <= rx_sync ? bspi_pkg::PH_IDLE : bspi_pkg::PH_DATA;
                  end
               end
               bspi_pkg::PH_DATA: begin
                  if (rx_cnt == bit_end) begin
                     rx_cnt   <= `BSPI_CNT_RST;
                     rx_shift <= {rx_sync, rx_shift[7:1]};
                     rx_bit   <= rx_bit + 3'h1;
                     if (rx_bit == 3'h7) begin
                        rx_ph <= bspi_pkg::PH_STOP;
                     end
                  end
               end
               bspi_pkg::PH_STOP: begin
                  if (rx_cnt == bit_end) begin
                     rx_valid <= 1'b1;
                     rx_ferr  <= !rx_sync;
                     rx_ph    <= bspi_pkg::PH_IDLE;
                  end
               end
               default: begin
                  rx_ph <= bspi_pkg::PH_IDLE;
               end
            endcase
         end
      end
   end

   // Eight-word queue decouples byte generation from the slow line
   bspi_fifo #(
      .WIDTH (`BSPI_FIFO_W),
      .DEPTH (`BSPI_FIFO_D)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .ce        (ce),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   assign f_out_ready = tx_ph == bspi_pkg::PH_IDLE;

   // Byte transmitter, one start, eight data, one stop
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_ph    <= bspi_pkg::PH_IDLE;
         tx_cnt   <= `BSPI_CNT_RST;
         tx_bit   <= 3'h0;
         tx_shift <= 8'h00;
         txd      <= 1'b1;
      end else if (ce) begin
         tx_cnt <= tx_cnt + CW'(1);
         unique case (tx_ph)
            bspi_pkg::PH_IDLE: begin
               txd    <= 1'b1;
               tx_cnt <= `BSPI_CNT_RST;
               if (f_out_valid) begin
                  tx_shift <= f_out_data;
                  txd      <= 1'b0;
                  tx_ph    <= bspi_pkg::PH_START;
               end
            end
            bspi_pkg::PH_START: begin
               if (tx_cnt == bit_end) begin
                  tx_cnt <= `BSPI_CNT_RST;
                  tx_bit <= 3'h0;
                  txd    <= tx_shift[0];
                  tx_ph  <= bspi_pkg::PH_DATA;
               end
            end
            bspi_pkg::PH_DATA: begin
               if (tx_cnt == bit_end) begin
                  tx_cnt   <= `BSPI_CNT_RST;
                  tx_bit   <= tx_bit + 3'h1;
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  txd      <= (tx_bit == 3'h7) ? 1'b1 : tx_shift[1];
                  if (tx_bit == 3'h7) begin
                     tx_ph <= bspi_pkg::PH_STOP;
                  end
               end
            end
            bspi_pkg::PH_STOP: begin
               if (tx_cnt == bit_end) begin
                  tx_ph <= bspi_pkg::PH_IDLE;
               end
            end
            default: begin
               tx_ph <= bspi_pkg::PH_IDLE;
            end
         endcase
      end
   end

   // Status decodes of the sequencer state
   assign baud_locked = !in_ab(state);
   assign cmd_wait    = state == bspi_pkg::ST_CMD;
   assign halted      = state == bspi_pkg::ST_ERR && err_cnt == `BSPI_ERR_LAST &&
                        !f_out_valid && tx_ph == bspi_pkg::PH_IDLE;

endmodule

`default_nettype wire

// File: src/bspi_defines.svh
`ifndef BSPI_DEFINES_SVH
`define BSPI_DEFINES_SVH

// Matching and command bytes
`define BSPI_SYNC1_A      8'h86
`define BSPI_SYNC1_B      8'h30
`define BSPI_SYNC2_A      8'h79
`define BSPI_SYNC2_B      8'hCF
`define BSPI_CMD_INFO     8'hC0

// Error codes and repeat count
`define BSPI_ERR_FRAME    8'hA1
`define BSPI_ERR_CMD      8'hA3
`define BSPI_ERR_OVR      8'h63
`define BSPI_ERR_LAST     2'h3

// Report framing
`define BSPI_START_MARK   8'h3A
`define BSPI_PAYLOAD_CNT  8'h13
`define BSPI_ADDR_LEN     8'h03
`define BSPI_RSV_FIRST    8'hFD
`define BSPI_RSV_ZERO     8'h00
`define BSPI_ROM_SIZE     8'h80
`define BSPI_ROM_BLOCKS   8'h01
`define BSPI_FLASH_START  24'h008000
`define BSPI_FLASH_END    24'h00FFFF
`define BSPI_RAM_START    24'h000060
`define BSPI_RAM_END      24'h00083F

// Reply sequence positions
`define BSPI_IDX_PAY_LO   5'h03
`define BSPI_IDX_PAY_HI   5'h15
`define BSPI_IDX_LAST     5'h16

// Timing and widths
`define BSPI_CNT_W        16
`define BSPI_MIN_BIT      16'h0004
`define BSPI_CNT_RST      16'h0000
`define BSPI_FIFO_W       8
`define BSPI_FIFO_D       8

`endif

// File: src/bspi_pkg.sv
package bspi_pkg;

   // Command sequencer states
   typedef enum logic [8:0] {
      ST_AB_WAIT = 9'h001,
      ST_AB_LOW  = 9'h002,
      ST_AB_HIGH = 9'h004,
      ST_AB_TAIL = 9'h008,
      ST_ECHO    = 9'h010,
      ST_SYNC2   = 9'h020,
      ST_CMD     = 9'h040,
      ST_REPLY   = 9'h080,
      ST_ERR     = 9'h100
   } bspi_state_t;

   // Serial bit phases, shared by receiver and transmitter
   typedef enum logic [3:0] {
      PH_IDLE  = 4'h1,
      PH_START = 4'h2,
      PH_DATA  = 4'h4,
      PH_STOP  = 4'h8
   } bspi_phase_t;

endpackage

// File: src/bspi_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module bspi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Honest full and empty from the fill count
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage, no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (ce && push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers wrap on the power-of-two depth
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (ce) begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

// File: verif/bspi_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module bspi_top_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Watched pins
   input wire logic ce,
   input wire logic rxd,
   input wire logic txd,
   input wire logic baud_locked,
   input wire logic cmd_wait,
   input wire logic halted
);
   // One domain, so clock and reset are given once
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Once dead, only reset revives the device
   property p_halt_keep;
      halted |=> halted;
   endproperty
   a_halt_keep: assert property (p_halt_keep) else $error("halt flag dropped");

   // A dead device keeps its line idle
   property p_halt_mute;
      halted |-> txd;
   endproperty
   a_halt_mute: assert property (p_halt_mute) else $error("line active while halted");

   // No command taken once dead
   property p_halt_nocmd;
      halted |-> !cmd_wait;
   endproperty
   a_halt_nocmd: assert property (p_halt_nocmd) else $error("command wait while halted");

   // Halt only after the last stop bit has begun
   property p_halt_late;
      $rose(halted) |-> txd && $past(txd, 4);
   endproperty
   a_halt_late: assert property (p_halt_late) else $error("halt before last stop bit");

   // A start bit lasts at least the minimum bit time
   property p_start_bit;
      $fell(txd) |-> !txd [*4];
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit too short");

   // Every high run lasts at least one minimum bit
   property p_bit_high;
      $rose(txd) |-> txd [*4];
   endproperty
   a_bit_high: assert property (p_bit_high) else $error("high bit too short");

   // Nothing is sent before the rate is adjusted
   property p_tx_locked;
      $fell(txd) |-> baud_locked;
   endproperty
   a_tx_locked: assert property (p_tx_locked) else $error("send before rate lock");

   // Losing the rate on a bad second byte sends nothing
   property p_unlock_quiet;
      $fell(baud_locked) |-> txd [*8];
   endproperty
   a_unlock_quiet: assert property (p_unlock_quiet) else $error("line active at rate loss");
endmodule

`default_nettype wire

// File: verif/bspi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module bspi_ctrl_model #(
   parameter int BIT = 8
) (
   // Clock
   input wire logic  ref_clk,
   // Link pins
   output var logic  rxd,
   input wire logic  txd
);
   logic [7:0] rx_q [$];
   logic [7:0] sh;

   // Idle line is high between frames
   initial rxd = 1'b1;

   // One 8N1 frame, LSB first; a low stop bit makes a framing fault
   task automatic send(input logic [7:0] b, input logic stp);
      logic [9:0] f;
      f = {stp, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge ref_clk) rxd = f[i];
         repeat (BIT - 1) @(negedge ref_clk);
      end
      @(negedge ref_clk) rxd = 1'b1;
   endtask

   // Receiver samples mid-bit at the fixed rate the device was taught
   initial forever begin
      @(negedge txd);
      // Falling edges keep sampling clear of the launching edge
      repeat (BIT / 2) @(negedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(negedge ref_clk);
         sh[i] = txd;
      end
      rx_q.push_back(sh);
      repeat (BIT) @(negedge ref_clk);
   end
endmodule

`default_nettype wire

// File: verif/boot_serial_product_info_reply_tb.sv
`timescale 1ns/1ps
`default_nettype none

module boot_serial_product_info_reply_tb;
   localparam int BIT = 8;
   localparam int LIMIT = 60000;

   logic       ref_clk;
   logic       rst_b;
   wire        rxd;
   logic       txd;
   logic       baud_locked;
   logic       cmd_wait;
   logic       halted;
   logic       ce;
   int         n_mismatch;
   int         samples_checked;
   int         cyc;
   logic [7:0] rep [$];

   // Free running clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Enable driven so one scenario can freeze the device
   bspi_top bspi_top_i (.ref_clk, .rst_b, .ce, .rxd, .txd, .baud_locked,
      .cmd_wait, .halted);
   bspi_ctrl_model #(.BIT(BIT)) bspi_ctrl_model_i (.ref_clk, .rxd, .txd);

   task automatic print_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t byte %h, wanted %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t flag %b, wanted %b", $time, g, e);
      end
   endtask

   // Wait, bounded, for n received bytes and check none extra came
   task automatic take(input int n);
      int w;
      w = 0;
      while (bspi_ctrl_model_i.rx_q.size() < n && w < 12 * BIT * n + 400) begin
         @(negedge ref_clk);
         w++;
      end
      rep = bspi_ctrl_model_i.rx_q;
      bspi_ctrl_model_i.rx_q = {};
      chk1(rep.size() == n, 1'b1);
   endtask

   task automatic do_reset();
      @(negedge ref_clk) rst_b = 1'b0;
      repeat (16) @(negedge ref_clk);
      chk1(txd, 1'b1);
      chk1(baud_locked, 1'b0);
      chk1(halted, 1'b0);
      rst_b = 1'b1;
      bspi_ctrl_model_i.rx_q = {};
   endtask

   task automatic sync(input logic [7:0] a, input logic [7:0] b);
      bspi_ctrl_model_i.send(a, 1'b1);
      take(1);
      chk8(rep[0], a);
      bspi_ctrl_model_i.send(b, 1'b1);
      take(1);
      chk8(rep[0], b);
      chk1(cmd_wait, 1'b1);
   endtask

   // Full report: echo, frame, payload, checksum, then back to waiting
   task automatic info();
      logic [7:0] e [$];
      logic [7:0] s;
      e = {8'hC0, 8'h3A, 8'h13, 8'h03, 8'hFD, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01,
           8'h00, 8'h80, 8'h00, 8'h00, 8'hFF, 8'hFF,
           8'h00, 8'h00, 8'h60, 8'h00, 8'h08, 8'h3F};
      s = 8'h00;
      for (int i = 3; i < 22; i++) s += e[i];
      bspi_ctrl_model_i.send(8'hC0, 1'b1);
      take(23);
      for (int i = 0; i < 22; i++) chk8(rep[i], e[i]);
      chk8(rep[22], 8'h00 - s);
      chk8(rep[22] + s, 8'h00);
      chk1(cmd_wait, 1'b1);
   endtask

   // Frozen device misses a whole frame and keeps waiting
   task automatic freeze();
      repeat (20 * BIT) @(negedge ref_clk);
      ce = 1'b0;
      bspi_ctrl_model_i.send(8'hC0, 1'b1);
      repeat (4) @(negedge ref_clk);
      ce = 1'b1;
      repeat (30 * BIT) @(negedge ref_clk);
      take(0);
      chk1(cmd_wait, 1'b1);
   endtask

   // Wrong second byte is ignored and autobaud starts over
   task automatic bad_sync();
      do_reset();
      bspi_ctrl_model_i.send(8'h30, 1'b1);
      take(1);
      chk8(rep[0], 8'h30);
      bspi_ctrl_model_i.send(8'h55, 1'b1);
      repeat (30 * BIT) @(negedge ref_clk);
      take(0);
      chk1(baud_locked, 1'b0);
      sync(8'h30, 8'hCF);
   endtask

   // Refused command: code three times, then silence until reset
   task automatic err(input logic [7:0] c, input logic stp, input logic twice,
                      input logic [7:0] code);
      do_reset();
      sync(8'h86, 8'h79);
      bspi_ctrl_model_i.send(c, stp);
      if (twice)
         bspi_ctrl_model_i.send(8'hC0, 1'b1);
      take(twice ? 26 : 3);
      for (int i = 0; i < 3; i++) chk8(rep[rep.size() - 3 + i], code);
      repeat (2 * BIT) @(negedge ref_clk);
      chk1(halted, 1'b1);
      bspi_ctrl_model_i.send(8'hC0, 1'b1);
      repeat (30 * BIT) @(negedge ref_clk);
      take(0);
   endtask

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      n_mismatch = 0;
      samples_checked = 0;
      cyc = 0;
      do_reset();
      sync(8'h86, 8'h79);
      info();
      info();
      freeze();
      info();
      bad_sync();
      info();
      err(8'h55, 1'b1, 1'b0, 8'hA3);
      err(8'hC0, 1'b0, 1'b0, 8'hA1);
      err(8'hC0, 1'b1, 1'b1, 8'h63);
      print_verdict();
   end
endmodule

bind bspi_top bspi_top_asserts bspi_top_asserts_i (.ref_clk, .rst_b, .ce, .rxd, .txd,
   .baud_locked, .cmd_wait, .halted);

`default_nettype wire
